/* File: common/sspc_consts.svh */
// Constants shared by the scan and purge control block
`ifndef SSPC_CONSTS_SVH
`define SSPC_CONSTS_SVH

// =====================================================================
// Geometry
`define SSPC_ADDR_W      11
`define SSPC_DATA_W      2
`define SSPC_CNT_W       2
`define SSPC_DEPTH       2048
`define SSPC_QTR_HI      10
`define SSPC_QTR_LO      9

// =====================================================================
// Scan chain
`define SSPC_CHAIN_LEN   21
`define SSPC_CHAIN_MSB   20

// =====================================================================
// Purge counter values (four cycles: 0,1,2,3)
`define SSPC_CNT_IDLE    2'h0
`define SSPC_CNT_ONE     2'h1
`define SSPC_CNT_LAST    2'h3

// =====================================================================
// Reset values
`define SSPC_BIT_CLR     1'h0
`define SSPC_BIT_SET     1'h1
`define SSPC_DATA_CLR    2'h0
`define SSPC_ADDR_CLR    11'h000

`endif

/* File: common/sspc_pkg.sv */
// Types shared by the scan and purge control block
package sspc_pkg;
  `include "sspc_consts.svh"

  // =====================================================================
  // Scan chain: bit 0 sits next to the serial input, bit 20 drives out
  typedef struct packed {
    logic                      q1;
    logic                      wd1;
    logic [`SSPC_ADDR_W-1:0]   addr;
    logic [`SSPC_CNT_W-1:0]    cnt;
    logic                      clr_b;
    logic                      sel_b;
    logic                      wr_b;
    logic                      gate_b;
    logic                      wd0;
    logic                      q0;
  } sspc_chain_t;

  // =====================================================================
  // Values that pass through the output latch
  typedef struct packed {
    logic                      oe;
    logic [`SSPC_DATA_W-1:0]   data;
    logic                      scan;
  } sspc_out_t;

  // =====================================================================
  // Sequencing mode, one-hot
  typedef enum logic [2:0] {
    SSPC_RUN  = 3'h1,
    SSPC_SCAN = 3'h2,
    SSPC_EXIT = 3'h4
  } sspc_mode_t;
endpackage

/* File: rtl/sspc_array.sv */
// Flip-flop storage array with one write port and a quarter-wise purge
`timescale 1ns/1ps
`include "sspc_consts.svh"
module sspc_array (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     wr_en,
  input  wire logic [`SSPC_ADDR_W-1:0]  addr,
  input  wire logic [`SSPC_DATA_W-1:0]  wr_data,
  input  wire logic                     clr_en,
  input  wire logic [`SSPC_CNT_W-1:0]   clr_qtr,
  output      logic [`SSPC_DATA_W-1:0]  rd_data
);
  import sspc_pkg::*;

  logic [`SSPC_DATA_W-1:0] mem_reg [`SSPC_DEPTH];

  // =====================================================================
  // Read port
  assign rd_data = mem_reg[addr];

  // =====================================================================
  // Storage; a purge step clears the quarter named by the counter,
  // which spreads the clear over four cycles instead of one huge fanout
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `SSPC_DEPTH; i++) begin
        mem_reg[i] <= `SSPC_DATA_CLR;
      end
    end else begin
      for (int i = 0; i < `SSPC_DEPTH; i++) begin
        if (clr_en && (i[`SSPC_QTR_HI:`SSPC_QTR_LO] == clr_qtr)) begin
          mem_reg[i] <= `SSPC_DATA_CLR;
        end else if (wr_en && (i[`SSPC_ADDR_W-1:0] == addr)) begin
          mem_reg[i] <= wr_data;
        end
      end
    end
  end
endmodule

/* File: rtl/sspc_out_latch.sv */
// Gated output stage standing in for the transparent output latches
`timescale 1ns/1ps
`include "sspc_consts.svh"
module sspc_out_latch (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              gate,
  input  wire logic              hold,
  input  wire sspc_pkg::sspc_out_t d,
  output      sspc_pkg::sspc_out_t q
);
  import sspc_pkg::*;

  // =====================================================================
  // Follows while the gate is high, keeps its value while low; the
  // data half also keeps still while scanning so the pins stay frozen.
  // Sampled on the clock, so it lags a true latch by one cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (gate) begin
      q.scan <= d.scan;
      if (!hold) begin
        q.oe   <= d.oe;
        q.data <= d.data;
      end
    end
  end
endmodule

/* File: rtl/sspc_scan_ctrl.sv */
// Scan chain, purge sequencer and cycle decoder of a registered SRAM
// Functional notes
// - Scan enable high turns the input registers into a shift chain.
// - Each shift loads serial in at stage 0, serial out from stage 20.
// - Serial out passes the output latch gate like the data outputs.
// - While scanning, no array writes and data outputs hold.
// - First edge after scan ends does a last shift, then acts.
// - Exit with gate low and idle counter runs the scanned cycle.
// - Exit with gate high and idle counter shows scanned outputs only.
// - Exit with nonzero counter disables outputs and resumes the purge.
// - Purge state is clear request bit plus two-bit counter.
// - Purge starts when clear request and cycle gate registers are low.
// - Counter goes to 1 next edge; inputs ignored until it wraps.
// - Counter bits are scan chain stages.
// - Chain order q0,d0,gate,wr,sel,clr,cnt0,cnt1,addr0-10,d1,q1.
// - A fresh purge clears whole array in four cycles, outputs disabled.
// - Gate high holds outputs except after a scan exit, and blocks writes and purge starts.
// - All inputs but reset, the latch gate included, are taken on the rising edge.
// - Output latch follows while gate high, holds while low.
`timescale 1ns/1ps
`include "sspc_consts.svh"
module sspc_scan_ctrl (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     scan_shift_enable,
  input  wire logic                     serial_scan_in,
  input  wire logic                     output_latch_gate,
  input  wire logic                     cycle_gate_b,
  input  wire logic                     clear_req_b,
  input  wire logic                     chip_select_b,
  input  wire logic                     write_strobe_b,
  input  wire logic [`SSPC_ADDR_W-1:0]  word_index,
  input  wire logic                     write_in_bit0,
  input  wire logic                     write_in_bit1,
  output      logic                     read_out_bit0,
  output      logic                     read_out_bit1,
  output      logic                     read_out_en,
  output      logic                     serial_scan_out
);
  import sspc_pkg::*;

  // =====================================================================
  // Helpers

  // One shift of the chain toward the serial output
  function automatic sspc_chain_t sspc_shift(input sspc_chain_t c,
                                             input logic        b);
    sspc_chain_t r;
    r = sspc_chain_t'({c[`SSPC_CHAIN_MSB-1:0], b});
    return r;
  endfunction

  // Purge counter advance, wrapping at four
  function automatic logic [`SSPC_CNT_W-1:0] sspc_cnt_inc(
      input logic [`SSPC_CNT_W-1:0] c);
    logic [`SSPC_CNT_W-1:0] r;
    r = c + `SSPC_CNT_ONE;
    return r;
  endfunction

  // =====================================================================
  // State
  sspc_chain_t             chain_reg;
  sspc_chain_t             chain_next;
  sspc_mode_t              mode_reg;
  sspc_mode_t              mode_next;
  logic                    oe_reg;
  logic                    oe_next;

  // =====================================================================
  // Decoded conditions
  wire logic               in_scan;
  wire logic               prev_scan;
  wire logic               from_exit;
  wire logic               run_edge;
  wire logic               cnt_busy;
  wire logic               cnt_last;
  wire logic               purge_start;
  wire logic               purge_step;
  wire logic               op_live;
  wire logic               op_hold;
  wire logic               op_write;
  wire logic               op_read;
  wire logic               op_desel;
  wire logic               nop_exit;
  wire logic               capture;
  wire logic               out_hold;
  wire logic [`SSPC_DATA_W-1:0] rd_data;
  wire logic [`SSPC_DATA_W-1:0] wr_data;
  wire logic [`SSPC_CNT_W-1:0]  cnt_inc;
  sspc_out_t               out_d;
  sspc_out_t               out_q;

  // Scan mode in this cycle and in the one before
  assign in_scan   = scan_shift_enable;
  assign prev_scan = (mode_reg == SSPC_SCAN);
  assign from_exit = (mode_reg == SSPC_EXIT);

  // An edge that runs the registered cycle: neither shifting nor the
  // final shift of a scan exit
  assign run_edge  = !in_scan && !prev_scan;

  // Purge sequencer: clear request plus two-bit counter
  assign cnt_busy    = (chain_reg.cnt != `SSPC_CNT_IDLE);
  assign cnt_last    = (chain_reg.cnt == `SSPC_CNT_LAST);
  assign cnt_inc     = sspc_cnt_inc(chain_reg.cnt);
  // A fresh start needs both active-low bits low; a busy counter
  // keeps going regardless of the gate, e.g. after a scanned-in state
  assign purge_start = !chain_reg.gate_b && !chain_reg.clr_b;
  assign purge_step  = run_edge && (cnt_busy || purge_start);

  // Ordinary cycle decode of the registered inputs
  assign op_live  = run_edge && !purge_step;
  assign op_hold  = op_live && chain_reg.gate_b;
  assign op_write = op_live && !chain_reg.gate_b &&
                    !chain_reg.sel_b && !chain_reg.wr_b;
  assign op_read  = op_live && !chain_reg.gate_b &&
                    !chain_reg.sel_b && chain_reg.wr_b;
  assign op_desel = op_live && !chain_reg.gate_b &&
                    chain_reg.sel_b && chain_reg.wr_b;

  // Exit with a high gate: no array access, outputs show scan stages
  assign nop_exit = from_exit && op_hold;

  // Inputs are taken on every running edge except inside a purge;
  // the edge that wraps the counter takes them again
  assign capture  = run_edge && (!purge_step || cnt_last);

  assign wr_data  = {chain_reg.wd1, chain_reg.wd0};

  // =====================================================================
  // Mode sequencing; scan enable wins over everything else
  always_comb begin
    mode_next = SSPC_RUN;
    case (mode_reg)
      SSPC_RUN: begin
        mode_next = in_scan ? SSPC_SCAN : SSPC_RUN;
      end
      SSPC_SCAN: begin
        mode_next = in_scan ? SSPC_SCAN : SSPC_EXIT;
      end
      SSPC_EXIT: begin
        mode_next = in_scan ? SSPC_SCAN : SSPC_RUN;
      end
      default: begin
        mode_next = SSPC_RUN;
      end
    endcase
  end

  // =====================================================================
  // Chain next value: shift while scanning and on the exit edge,
  // otherwise update counter, output stages and captured inputs
  always_comb begin
    chain_next = chain_reg;
    if (in_scan || prev_scan) begin
      chain_next = sspc_shift(chain_reg, serial_scan_in);
    end else begin
      if (purge_step) begin
        chain_next.cnt = cnt_inc;
      end
      if (op_read) begin
        chain_next.q0 = rd_data[0];
        chain_next.q1 = rd_data[1];
      end
      if (capture) begin
        chain_next.gate_b = cycle_gate_b;
        chain_next.clr_b  = clear_req_b;
        chain_next.sel_b  = chip_select_b;
        chain_next.wr_b   = write_strobe_b;
        chain_next.addr   = word_index;
        chain_next.wd0    = write_in_bit0;
        chain_next.wd1    = write_in_bit1;
      end
    end
  end

  // =====================================================================
  // Output enable: a purge or a deselected read turns the outputs off,
  // a read or a no-op exit turns them on, anything else keeps them
  always_comb begin
    oe_next = oe_reg;
    if (purge_step) begin
      oe_next = `SSPC_BIT_CLR;
    end else if (op_read || nop_exit) begin
      oe_next = `SSPC_BIT_SET;
    end else if (op_desel) begin
      oe_next = `SSPC_BIT_CLR;
    end
  end

  // =====================================================================
  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chain_reg <= '0;
      mode_reg  <= SSPC_RUN;
      oe_reg    <= `SSPC_BIT_CLR;
    end else begin
      chain_reg <= chain_next;
      mode_reg  <= mode_next;
      oe_reg    <= oe_next;
    end
  end

  // =====================================================================
  // Array; writes and purge clears only happen on running edges
  sspc_array u_array (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (op_write),
    .addr    (chain_reg.addr),
    .wr_data (wr_data),
    .clr_en  (purge_step),
    .clr_qtr (chain_reg.cnt),
    .rd_data (rd_data)
  );

  // =====================================================================
  // Output latch. Data pins freeze while the chain is moving, and on
  // the cycle after a running exit so scanned q stages do not flash.
  assign out_hold = prev_scan || in_scan ||
                    (from_exit && !nop_exit);
  assign out_d.oe   = oe_reg;
  assign out_d.data = {chain_reg.q1, chain_reg.q0};
  assign out_d.scan = chain_reg[`SSPC_CHAIN_MSB];

  sspc_out_latch u_out_latch (
    .clk   (clk),
    .rst_b (rst_b),
    .gate  (output_latch_gate),
    .hold  (out_hold),
    .d     (out_d),
    .q     (out_q)
  );

  // Pins come straight from the latch flip-flops
  assign read_out_bit0   = out_q.data[0];
  assign read_out_bit1   = out_q.data[1];
  assign read_out_en     = out_q.oe;
  assign serial_scan_out = out_q.scan;
endmodule

/* File: verif/sspc_scan_host.sv */
// Scan controller model that loads and unloads the chain serially
`timescale 1ns/1ps
module sspc_scan_host (
  input  wire logic clk,
  input  wire logic serial_scan_out,
  output      logic scan_shift_enable,
  output      logic serial_scan_in
);
  import sspc_pkg::*;
  initial begin
    scan_shift_enable = 1'h0;
    serial_scan_in    = 1'h0;
  end
  // ======
  // Far stage first; the last bit rides the exit edge with enable low,
  // so 20 enabled edges plus the exit make one full 21-stage load
  task automatic shift(input sspc_chain_t v, output sspc_chain_t u);
    for (int i = 20; i >= 0; i--) begin
      scan_shift_enable <= (i != 0);
      serial_scan_in    <= v[i];
      @(posedge clk);
      #1 u[i] = serial_scan_out;
    end
    serial_scan_in <= ~v[0]; // Line is stale once the frame ends
  endtask
endmodule

/* File: verif/sspc_scan_sva.sv */
// Port checker for the scan and purge control block
`timescale 1ns/1ps
`include "sspc_consts.svh"
module sspc_scan_sva (
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire logic                    scan_shift_enable,
  input wire logic                    serial_scan_in,
  input wire logic                    output_latch_gate,
  input wire logic                    cycle_gate_b,
  input wire logic                    clear_req_b,
  input wire logic                    chip_select_b,
  input wire logic                    write_strobe_b,
  input wire logic [`SSPC_ADDR_W-1:0] word_index,
  input wire logic                    write_in_bit0,
  input wire logic                    write_in_bit1,
  input wire logic                    read_out_bit0,
  input wire logic                    read_out_bit1,
  input wire logic                    read_out_en,
  input wire logic                    serial_scan_out
);
  logic [4:0] run_reg;
  logic [2:0] quiet_reg;
  logic       se_d_reg;
  logic [2:0] pins;
  assign pins = {read_out_en, read_out_bit1, read_out_bit0};
  // ======
  // Shift edges in a row, and edges free of scan and purge requests;
  // both saturate so long runs never wrap back into an antecedent
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_reg   <= 5'h00;
      quiet_reg <= 3'h0;
      se_d_reg  <= 1'h0;
    end else begin
      se_d_reg  <= scan_shift_enable;
      run_reg   <= !(scan_shift_enable || se_d_reg) ? 5'h00 :
                   run_reg + {4'h0, run_reg != 5'h1f};
      quiet_reg <= (scan_shift_enable || !clear_req_b) ? 3'h0 :
                   quiet_reg + {2'h0, quiet_reg != 3'h7};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Exit edge after a full load: stage j holds serial in of j edges ago
  sequence exit_s;
    !scan_shift_enable && $past(scan_shift_enable) && run_reg >= 5'h14;
  endsequence
  // ======
  chain_shift_a: assert property (
    $past(run_reg) >= 5'h15 && $past(output_latch_gate) |->
    serial_scan_out == $past(serial_scan_in, 22))
    else $error("serial out does not carry the bit shifted in");
  scan_hold_a: assert property (
    $past(scan_shift_enable) |-> $stable({read_out_bit1, read_out_bit0}))
    else $error("data outputs moved while scanning");
  purge_off_a: assert property (
    (!scan_shift_enable && !$past(scan_shift_enable) &&
     !$past(scan_shift_enable, 2) && !clear_req_b && !cycle_gate_b)
    ##1 !scan_shift_enable ##1 (output_latch_gate && !scan_shift_enable)
    |=> !read_out_en)
    else $error("outputs enabled during purge");
  read_on_a: assert property (
    (quiet_reg >= 3'h6 && !scan_shift_enable && !cycle_gate_b &&
     !chip_select_b && write_strobe_b) ##1 !scan_shift_enable
    ##1 (output_latch_gate && !scan_shift_enable) |=> read_out_en)
    else $error("read did not enable outputs");
  gate_hold_a: assert property (
    (quiet_reg >= 3'h6 && !scan_shift_enable && cycle_gate_b)
    ##1 output_latch_gate |-> ##2 $stable(pins))
    else $error("outputs moved with cycle gate high");
  latch_hold_a: assert property (
    !output_latch_gate |=> $stable({pins, serial_scan_out}))
    else $error("latch changed with gate low");
  nop_exit_a: assert property (
    exit_s ##0 ($past(serial_scan_in, 2) && !$past(serial_scan_in, 6) &&
    !$past(serial_scan_in, 7)) ##1 !scan_shift_enable
    ##1 (output_latch_gate && !scan_shift_enable) |=> pins ==
    {1'h1, $past(serial_scan_in, 23), $past(serial_scan_in, 3)})
    else $error("no-op exit did not show scanned outputs");
  purge_exit_a: assert property (
    exit_s ##0 ($past(serial_scan_in, 6) || $past(serial_scan_in, 7))
    ##1 !scan_shift_enable ##1 (output_latch_gate && !scan_shift_enable)
    |=> !read_out_en)
    else $error("exit into purge left outputs enabled");
  cover property (exit_s);
  cover property (!scan_shift_enable && !clear_req_b && !cycle_gate_b);
  cover property (!output_latch_gate ##1 output_latch_gate);
endmodule

bind sspc_scan_ctrl sspc_scan_sva u_sspc_scan_sva (
  .clk(clk), .rst_b(rst_b), .scan_shift_enable(scan_shift_enable),
  .serial_scan_in(serial_scan_in), .output_latch_gate(output_latch_gate),
  .cycle_gate_b(cycle_gate_b), .clear_req_b(clear_req_b),
  .chip_select_b(chip_select_b), .write_strobe_b(write_strobe_b),
  .word_index(word_index), .write_in_bit0(write_in_bit0),
  .write_in_bit1(write_in_bit1), .read_out_bit0(read_out_bit0),
  .read_out_bit1(read_out_bit1), .read_out_en(read_out_en),
  .serial_scan_out(serial_scan_out));

/* File: verif/testbench.sv */
// Self-checking bench for the scan and purge control block
`timescale 1ns/1ps
module testbench;
  import sspc_pkg::*;
  localparam logic [3:0] RD = 4'h5, WR = 4'h4, IDLE = 4'hf, PRG = 4'h3;
  logic        clk               = 1'h0;
  logic        rst_b             = 1'h0;
  logic        output_latch_gate = 1'h1;
  logic        cycle_gate_b      = 1'h1;
  logic        clear_req_b       = 1'h1;
  logic        chip_select_b     = 1'h1;
  logic        write_strobe_b    = 1'h1;
  logic [10:0] word_index        = 11'h000;
  logic [1:0]  wdata             = 2'h0;
  logic        read_out_bit0, read_out_bit1, read_out_en, serial_scan_out;
  logic        scan_shift_enable, serial_scan_in;
  logic [2:0]  pins;
  int          num_errors        = 0;
  int          compares          = 0;
  sspc_chain_t got, ld;
  assign pins = {read_out_en, read_out_bit1, read_out_bit0};
  sspc_scan_ctrl u_sspc_scan_ctrl (
    .clk(clk), .rst_b(rst_b), .scan_shift_enable(scan_shift_enable),
    .serial_scan_in(serial_scan_in), .output_latch_gate(output_latch_gate),
    .cycle_gate_b(cycle_gate_b), .clear_req_b(clear_req_b),
    .chip_select_b(chip_select_b), .write_strobe_b(write_strobe_b),
    .word_index(word_index), .write_in_bit0(wdata[0]),
    .write_in_bit1(wdata[1]), .read_out_bit0(read_out_bit0),
    .read_out_bit1(read_out_bit1), .read_out_en(read_out_en),
    .serial_scan_out(serial_scan_out));
  sspc_scan_host u_sspc_scan_host (
    .clk(clk), .serial_scan_out(serial_scan_out),
    .scan_shift_enable(scan_shift_enable), .serial_scan_in(serial_scan_in));
  initial forever #20 clk = ~clk;
  // ======
  // Helpers: pins are {enable, bit1, bit0}; a read shows two edges late
  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic drive(input logic [3:0] c, input logic [10:0] a,
                       input logic [1:0] d);
    {cycle_gate_b, clear_req_b, chip_select_b, write_strobe_b} <= c;
    word_index <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic wr(input logic [10:0] a, input logic [1:0] d);
    drive(WR, a, d);
    drive(IDLE, 11'h000, 2'h0);
  endtask
  task automatic rd(input logic [10:0] a, input logic [2:0] e);
    drive(RD, a, 2'h0);
    drive(IDLE, 11'h000, 2'h0);
    @(posedge clk);
    #1 chk(pins, e);
  endtask
  // ======
  // Scenarios
  task automatic t_rw();
    wr(11'h005, 2'h2);
    wr(11'h606, 2'h1);
    rd(11'h005, 3'h6);
    rd(11'h606, 3'h5);
    // Deselected read turns the outputs off, data stages keep their value
    drive(4'h7, 11'h005, 2'h0);
    drive(IDLE, 11'h000, 2'h0);
    @(posedge clk);
    #1 chk(pins, 3'h1);
  endtask
  task automatic t_gate();
    drive(4'hc, 11'h005, 2'h1);
    drive(IDLE, 11'h000, 2'h0);
    rd(11'h005, 3'h6);
    drive(4'hd, 11'h606, 2'h0);
    drive(IDLE, 11'h000, 2'h0);
    @(posedge clk);
    #1 chk(pins, 3'h6);
  endtask
  task automatic t_latch();
    output_latch_gate <= 1'h0;
    rd(11'h606, 3'h6);
    output_latch_gate <= 1'h1;
    @(posedge clk);
    #1 chk(pins, 3'h5);
  endtask
  // A write issued right behind the request must be swallowed
  task automatic t_purge();
    drive(PRG, 11'h000, 2'h0);
    drive(WR, 11'h606, 2'h3);
    drive(IDLE, 11'h000, 2'h0);
    #1 chk(read_out_en, 1'h0);
    drive(IDLE, 11'h000, 2'h0);
    drive(IDLE, 11'h000, 2'h0);
    rd(11'h606, 3'h4);
    rd(11'h005, 3'h4);
  endtask
  // Chain fields from far end: q1,wd1,addr,cnt,clr,sel,wr,gate,wd0,q0
  task automatic t_nop();
    wr(11'h2a5, 2'h3);
    rd(11'h2a5, 3'h7);
    ld = {1'h1, 1'h0, 11'h2a5, 2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
    u_sspc_scan_host.shift(ld, got);
    chk(got, {1'h1, 1'h0, 11'h0, 2'h0, 4'hf, 1'h0, 1'h1});
    chk(pins, 3'h7);
    repeat (2) @(posedge clk);
    #1 chk(pins, 3'h6);
    rd(11'h2a5, 3'h7);
  endtask
  task automatic t_exec();
    ld = {1'h0, 1'h1, 11'h3c3, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
    u_sspc_scan_host.shift(ld, got);
    drive(IDLE, 11'h000, 2'h0);
    rd(11'h3c3, 3'h6);
  endtask
  task automatic t_pexit();
    wr(11'h7ff, 2'h3);
    wr(11'h001, 2'h1);
    ld = {1'h0, 1'h0, 11'h000, 2'h2, 1'h0, 3'h7, 1'h0, 1'h0};
    u_sspc_scan_host.shift(ld, got);
    repeat (2) @(posedge clk);
    #1 chk(read_out_en, 1'h0);
    drive(IDLE, 11'h000, 2'h0);
    drive(IDLE, 11'h000, 2'h0);
    rd(11'h7ff, 3'h4);
    rd(11'h001, 3'h5);
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reset releases into a purge, so wait it out before traffic
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    repeat (5) @(posedge clk);
    t_rw();
    t_gate();
    t_latch();
    t_purge();
    t_nop();
    t_exec();
    t_pexit();
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule
